// [src/dtp_timers.sv]
`timescale 1ns/1ps
// Functional notes
// - Two 8-bit counters, each with 6-bit prescaler.
// - Second prescaler internal or external; first internal.
// - Prescaler divides by one through sixty-four.
// - Prescaler ticks decrement counter from 1..256.
// - Both at terminal count raise timer interrupt.
// - Start, stop, resume, or restart from initial.
// - Single-pass halts at zero; modulo mode reloads.
// - Counters readable undisturbed; prescalers read as zero.
// - Second clock: internal divided by four, or external.
// - Timer input: clock, trigger, retrigger, or gate.
// - Lines 0 and 1 digital or comparator input; line 2 reads as zero while comparators are on.
// - Input lines feed port interrupts and timer input.
// - Second comparator both edges; first falling only.
// - Comparator outputs invalid two NOPs after enable.
// - Comparators route anywhere; disabled frees reference pin.
// - Comparators powered down in stop state.
// - Reset clears mode register and low prescaler bits.
// - Six request bits clear; reference line rising edge.
// - Port mode survives stop recovery via release pin.
module dtp_timers (
   input wire logic clk,
   input wire logic rst,
   input wire dtp_pkg::dtp_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] input_port_lines,
   input wire logic first_cmp_out,
   input wire logic second_cmp_out,
   input wire logic stop_state,
   input wire logic stop_release_pin,
   output logic comparator_power_en,
   output logic [5:0] irq_request,
   output logic [3:0] port_input_irqs,
   output logic first_timer_irq,
   output logic second_timer_irq
);

   typedef struct packed {
      logic [7:0] timer_mode;
      logic [7:0] first_pre;
      logic [7:0] second_pre;
      logic [7:0] first_init;
      logic [7:0] second_init;
      logic [7:0] port_mode;
      logic [5:0] irq_req;
      logic [3:0] port_irq;
      logic [1:0] div_cnt;
      logic [4:0] settle_cnt;
      logic [2:0] prev_lines;
      logic trig_seen;
      logic cmp_power;
      logic [7:0] rdata;
   } dtp_top_s;

   dtp_top_s s;
   dtp_top_s next_s;

   logic [7:0] first_count;
   logic [7:0] second_count;
   logic second_counting;
   logic first_term;
   logic second_term;
   logic first_restart;
   logic second_restart;
   logic first_run;
   logic second_run;
   logic int_tick;
   logic second_tick;
   logic analog;
   logic cmp_valid;
   logic [2:0] line_eff;
   logic [2:0] rise;
   logic [2:0] fall;
   logic tin;
   logic ext_src;
   logic trig_mode;
   logic trig_accept;
   logic sw_first_load;
   logic sw_second_load;
   logic [5:0] irq_set;
   logic [3:0] port_evt;
   logic [7:0] rd_value;
   dtp_pkg::dtp_tin_mode_e tin_mode;
   dtp_pkg::dtp_ch_cfg_s first_cfg;
   dtp_pkg::dtp_ch_cfg_s second_cfg;

   // Input lines and comparators
   always_comb begin
      analog = s.port_mode[dtp_pkg::IPM_ANALOG_BIT];
      cmp_valid = analog && (s.settle_cnt == 5'h00) && !stop_state;
      // An unsettled comparator holds its last level so no false edge appears
      line_eff[0] = analog ? (cmp_valid ? first_cmp_out : s.prev_lines[0]) : input_port_lines[0];
      line_eff[1] = analog ? (cmp_valid ? second_cmp_out : s.prev_lines[1]) : input_port_lines[1];
      // Reference pin is an ordinary line only while comparators are off
      line_eff[2] = analog ? 1'b0 : input_port_lines[2];
      rise = line_eff & ~s.prev_lines;
      fall = ~line_eff & s.prev_lines;
      port_evt = 4'h0;
      port_evt[dtp_pkg::IRQ_SECOND_CMP_BIT] = analog ? (rise[1] | fall[1]) : fall[1];
      port_evt[dtp_pkg::IRQ_REF_FALL_BIT] = !analog && fall[2];
      port_evt[dtp_pkg::IRQ_FIRST_CMP_BIT] = fall[0];
      port_evt[dtp_pkg::IRQ_REF_RISE_BIT] = !analog && rise[2];
      tin = line_eff[0];
   end

   // Timer sequencing
   always_comb begin
      tin_mode = dtp_pkg::dtp_tin_mode_e'(s.timer_mode[dtp_pkg::TMR_TIN_MODE_LSB +: 2]);
      ext_src = s.second_pre[dtp_pkg::PRE_EXT_BIT];
      int_tick = (s.div_cnt == dtp_pkg::DIV_LAST) && !stop_state;
      sw_first_load = reg_req.wr && (reg_req.addr == dtp_pkg::ADDR_TIMER_MODE)
         && reg_req.wdata[dtp_pkg::TMR_FIRST_LOAD_BIT];
      sw_second_load = reg_req.wr && (reg_req.addr == dtp_pkg::ADDR_TIMER_MODE)
         && reg_req.wdata[dtp_pkg::TMR_SECOND_LOAD_BIT];
      trig_mode = !ext_src && ((tin_mode == dtp_pkg::TIN_TRIG_ONCE) || (tin_mode == dtp_pkg::TIN_TRIG_RETRIG));
      // A one-shot trigger is ignored while its count is still running
      trig_accept = trig_mode && rise[0] && s.timer_mode[dtp_pkg::TMR_SECOND_EN_BIT]
         && ((tin_mode == dtp_pkg::TIN_TRIG_RETRIG) || !s.trig_seen || !second_counting);
      if (ext_src) begin
         second_tick = rise[0];
      end else if (tin_mode == dtp_pkg::TIN_GATE) begin
         second_tick = int_tick && tin;
      end else begin
         second_tick = int_tick;
      end
      first_restart = sw_first_load;
      second_restart = sw_second_load || trig_accept;
      first_run = s.timer_mode[dtp_pkg::TMR_FIRST_EN_BIT];
      second_run = s.timer_mode[dtp_pkg::TMR_SECOND_EN_BIT] && (!trig_mode || s.trig_seen);
      first_cfg.ratio = s.first_pre[dtp_pkg::PRE_RATIO_LSB +: 6];
      first_cfg.init = s.first_init;
      first_cfg.cont = s.first_pre[dtp_pkg::PRE_CONT_BIT];
      second_cfg.ratio = s.second_pre[dtp_pkg::PRE_RATIO_LSB +: 6];
      second_cfg.init = s.second_init;
      second_cfg.cont = s.second_pre[dtp_pkg::PRE_CONT_BIT];
   end

   // Read mux
   always_comb begin
      case (reg_req.addr)
         dtp_pkg::ADDR_TIMER_MODE: rd_value = s.timer_mode;
         dtp_pkg::ADDR_FIRST_COUNT: rd_value = first_count;
         dtp_pkg::ADDR_SECOND_COUNT: rd_value = second_count;
         dtp_pkg::ADDR_FIRST_PRESCALE: rd_value = dtp_pkg::READ_ZERO;
         dtp_pkg::ADDR_SECOND_PRESCALE: rd_value = dtp_pkg::READ_ZERO;
         dtp_pkg::ADDR_INPUT_PORT_MODE: rd_value = s.port_mode;
         dtp_pkg::ADDR_IRQ_REQUEST: rd_value = {2'b00, s.irq_req};
         dtp_pkg::ADDR_PORT_DATA: rd_value = {5'b00000, line_eff};
         default: rd_value = dtp_pkg::READ_ZERO;
      endcase
   end

   always_comb begin
      next_s = s;
      irq_set = {second_term, first_term, port_evt};
      next_s.port_irq = port_evt;
      next_s.prev_lines = line_eff;
      next_s.div_cnt = stop_state ? s.div_cnt : s.div_cnt + 2'h1;
      if (reg_req.rd) begin
         next_s.rdata = rd_value;
      end
      if (sw_second_load) begin
         next_s.trig_seen = 1'b0;
      end
      if (trig_accept) begin
         next_s.trig_seen = 1'b1;
      end
      if (reg_req.wr) begin
         case (reg_req.addr)
            // Load bits act once and are not stored
            dtp_pkg::ADDR_TIMER_MODE: next_s.timer_mode = reg_req.wdata & dtp_pkg::TMR_WRITE_MASK;
            dtp_pkg::ADDR_FIRST_PRESCALE: next_s.first_pre = reg_req.wdata;
            dtp_pkg::ADDR_SECOND_PRESCALE: next_s.second_pre = reg_req.wdata;
            dtp_pkg::ADDR_FIRST_COUNT: next_s.first_init = reg_req.wdata;
            dtp_pkg::ADDR_SECOND_COUNT: next_s.second_init = reg_req.wdata;
            dtp_pkg::ADDR_INPUT_PORT_MODE: begin
               next_s.port_mode = reg_req.wdata;
               if (reg_req.wdata[dtp_pkg::IPM_ANALOG_BIT] && !analog) begin
                  next_s.settle_cnt = dtp_pkg::CMP_SETTLE_LOAD;
               end
            end
            dtp_pkg::ADDR_IRQ_REQUEST: next_s.irq_req = reg_req.wdata[5:0];
            default: next_s.port_mode = s.port_mode;
         endcase
      end
      // A new event beats a clear written in the same cycle
      next_s.irq_req = next_s.irq_req | irq_set;
      if (stop_state) begin
         next_s.settle_cnt = dtp_pkg::CMP_SETTLE_LOAD;
      end else if (s.settle_cnt != 5'h00 && !(reg_req.wr && reg_req.addr == dtp_pkg::ADDR_INPUT_PORT_MODE)) begin
         next_s.settle_cnt = s.settle_cnt - 5'h01;
      end
      next_s.cmp_power = next_s.port_mode[dtp_pkg::IPM_ANALOG_BIT] && !stop_state;
      // Stop recovery restores timer state but leaves the port mode alone
      if (stop_release_pin) begin
         next_s.timer_mode = dtp_pkg::TIMER_MODE_RESET;
         next_s.first_pre[dtp_pkg::PRE_CONT_BIT] = 1'b0;
         next_s.second_pre[dtp_pkg::PRE_CONT_BIT] = 1'b0;
         next_s.second_pre[dtp_pkg::PRE_EXT_BIT] = 1'b0;
         next_s.irq_req = dtp_pkg::IRQ_REQUEST_RESET;
         next_s.trig_seen = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s.timer_mode <= dtp_pkg::TIMER_MODE_RESET;
         s.first_pre <= dtp_pkg::PRESCALE_RESET;
         s.second_pre <= dtp_pkg::PRESCALE_RESET;
         s.first_init <= dtp_pkg::COUNT_RESET;
         s.second_init <= dtp_pkg::COUNT_RESET;
         s.port_mode <= dtp_pkg::INPUT_PORT_MODE_RESET;
         s.irq_req <= dtp_pkg::IRQ_REQUEST_RESET;
         s.port_irq <= 4'h0;
         s.div_cnt <= 2'h0;
         s.settle_cnt <= 5'h00;
         s.prev_lines <= 3'h0;
         s.trig_seen <= 1'b0;
         s.cmp_power <= 1'b0;
         s.rdata <= dtp_pkg::READ_ZERO;
      end else begin
         s <= next_s;
      end
   end

   dtp_timer_channel u_first (
      .clk(clk),
      .rst(rst),
      .cfg(first_cfg),
      .restart(first_restart),
      .run(first_run),
      .tick(int_tick),
      .count(first_count),
      .counting(),
      .terminal(first_term)
   );

   dtp_timer_channel u_second (
      .clk(clk),
      .rst(rst),
      .cfg(second_cfg),
      .restart(second_restart),
      .run(second_run),
      .tick(second_tick),
      .count(second_count),
      .counting(second_counting),
      .terminal(second_term)
   );

   assign reg_rdata = s.rdata;
   assign comparator_power_en = s.cmp_power;
   assign irq_request = s.irq_req;
   assign port_input_irqs = s.port_irq;
   assign first_timer_irq = first_term;
   assign second_timer_irq = second_term;

endmodule

// [src/dtp_pkg.sv]
package dtp_pkg;

   // Register file addresses
   localparam logic [7:0] ADDR_PORT_DATA = 8'h03;
   localparam logic [7:0] ADDR_TIMER_MODE = 8'hf1;
   localparam logic [7:0] ADDR_SECOND_COUNT = 8'hf2;
   localparam logic [7:0] ADDR_SECOND_PRESCALE = 8'hf3;
   localparam logic [7:0] ADDR_FIRST_COUNT = 8'hf4;
   localparam logic [7:0] ADDR_FIRST_PRESCALE = 8'hf5;
   localparam logic [7:0] ADDR_INPUT_PORT_MODE = 8'hf7;
   localparam logic [7:0] ADDR_IRQ_REQUEST = 8'hfa;

   // Reset values
   localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] INPUT_PORT_MODE_RESET = 8'h00;
   localparam logic [5:0] IRQ_REQUEST_RESET = 6'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // timer_mode_control fields
   localparam int TMR_FIRST_LOAD_BIT = 0;
   localparam int TMR_FIRST_EN_BIT = 1;
   localparam int TMR_SECOND_LOAD_BIT = 2;
   localparam int TMR_SECOND_EN_BIT = 3;
   localparam int TMR_TIN_MODE_LSB = 4;
   localparam logic [7:0] TMR_WRITE_MASK = 8'h3a;

   // Prescale register fields
   localparam int PRE_CONT_BIT = 0;
   localparam int PRE_EXT_BIT = 1;
   localparam int PRE_RATIO_LSB = 2;

   // input_port_mode fields
   localparam int IPM_ANALOG_BIT = 1;

   // Interrupt request bits
   localparam int IRQ_SECOND_CMP_BIT = 0;
   localparam int IRQ_REF_FALL_BIT = 1;
   localparam int IRQ_FIRST_CMP_BIT = 2;
   localparam int IRQ_REF_RISE_BIT = 3;
   localparam int IRQ_FIRST_TIMER_BIT = 4;
   localparam int IRQ_SECOND_TIMER_BIT = 5;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int INTERNAL_DIV = 4;
   localparam int NOP_TIME_NS = 60;
   localparam int NOP_CYCLES = (NOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CMP_SETTLE_NOPS = 2;
   localparam int CMP_SETTLE_CYCLES = CMP_SETTLE_NOPS * NOP_CYCLES;
   localparam logic [1:0] DIV_LAST = 2'(INTERNAL_DIV - 1);
   localparam logic [4:0] CMP_SETTLE_LOAD = 5'(CMP_SETTLE_CYCLES);

   typedef enum logic [1:0] {
      TIN_FREE = 2'b00,
      TIN_GATE = 2'b01,
      TIN_TRIG_ONCE = 2'b10,
      TIN_TRIG_RETRIG = 2'b11
   } dtp_tin_mode_e;

   typedef enum logic [1:0] {
      CH_STOPPED = 2'b00,
      CH_COUNTING = 2'b01,
      CH_HALTED = 2'b10
   } dtp_ch_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dtp_reg_req_s;

   typedef struct packed {
      logic [5:0] ratio;
      logic [7:0] init;
      logic cont;
   } dtp_ch_cfg_s;

endpackage

// [src/dtp_timer_channel.sv]
`timescale 1ns/1ps
module dtp_timer_channel (
   input wire logic clk,
   input wire logic rst,
   input wire dtp_pkg::dtp_ch_cfg_s cfg,
   input wire logic restart,
   input wire logic run,
   input wire logic tick,
   output logic [7:0] count,
   output logic counting,
   output logic terminal
);

   typedef struct packed {
      dtp_pkg::dtp_ch_state_e state;
      logic [5:0] pre_cnt;
      logic [7:0] count;
      logic term;
   } dtp_ch_s;

   dtp_ch_s s;
   dtp_ch_s next_s;

   always_comb begin
      next_s = s;
      next_s.term = 1'b0;
      if (restart) begin
         next_s.pre_cnt = cfg.ratio;
         next_s.count = cfg.init;
         next_s.state = dtp_pkg::CH_COUNTING;
      end else begin
         case (s.state)
            dtp_pkg::CH_COUNTING: begin
               // Zero in either counter wraps, so it behaves as 64 or 256
               if (run && tick) begin
                  if (s.pre_cnt == 6'h01) begin
                     next_s.pre_cnt = cfg.ratio;
                     if (s.count == 8'h01) begin
                        next_s.term = 1'b1;
                        if (cfg.cont) begin
                           next_s.count = cfg.init;
                        end else begin
                           next_s.count = 8'h00;
                           next_s.state = dtp_pkg::CH_HALTED;
                        end
                     end else begin
                        next_s.count = s.count - 8'h01;
                     end
                  end else begin
                     next_s.pre_cnt = s.pre_cnt - 6'h01;
                  end
               end
            end
            dtp_pkg::CH_STOPPED: begin
               next_s.state = dtp_pkg::CH_STOPPED;
            end
            dtp_pkg::CH_HALTED: begin
               next_s.state = dtp_pkg::CH_HALTED;
            end
            default: begin
               next_s.state = dtp_pkg::CH_STOPPED;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{state: dtp_pkg::CH_STOPPED, pre_cnt: 6'h00, count: dtp_pkg::COUNT_RESET, term: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign count = s.count;
   assign counting = (s.state == dtp_pkg::CH_COUNTING);
   assign terminal = s.term;

endmodule

// [tb/dtp_timers_assertions.sv]
`timescale 1ns/1ps
module dtp_timers_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire dtp_pkg::dtp_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] input_port_lines,
   input wire logic stop_state,
   input wire logic comparator_power_en,
   input wire logic [5:0] irq_request,
   input wire logic [3:0] port_input_irqs,
   input wire logic first_timer_irq,
   input wire logic second_timer_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Fastest legal period is four system clocks, so a pulse never repeats sooner
   first_pulse_gap_a: assert property (first_timer_irq |=> !first_timer_irq [*3])
      else $error("first timer pulses too close");
   first_req_set_a: assert property (first_timer_irq |=> irq_request[4])
      else $error("first timer request not latched");
   second_req_set_a: assert property (second_timer_irq |=> irq_request[5])
      else $error("second timer request not latched");
   ref_rise_edge_a: assert property (port_input_irqs[3] |-> $past(input_port_lines[2]) && !$past(input_port_lines[2], 2))
      else $error("rise request without rising edge");
   ref_fall_edge_a: assert property (port_input_irqs[1] |-> !$past(input_port_lines[2]) && $past(input_port_lines[2], 2))
      else $error("fall request without falling edge");
   rise_latched_a: assert property (port_input_irqs[3] |-> irq_request[3])
      else $error("rise request not latched");
   stop_power_off_a: assert property (stop_state |=> !comparator_power_en)
      else $error("comparators powered in stop");
   prescale_read_zero_a: assert property (reg_req.rd && (reg_req.addr == dtp_pkg::ADDR_FIRST_PRESCALE ||
      reg_req.addr == dtp_pkg::ADDR_SECOND_PRESCALE) |=> reg_rdata == 8'h00)
      else $error("prescaler contents visible");
   cover property (first_timer_irq);
   cover property (second_timer_irq);
   cover property (port_input_irqs[3]);
   cover property ($rose(comparator_power_en));
endmodule

bind dtp_timers dtp_timers_assertions u_dtp_timers_assertions (.clk(clk), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .input_port_lines(input_port_lines), .stop_state(stop_state),
   .comparator_power_en(comparator_power_en), .irq_request(irq_request), .port_input_irqs(port_input_irqs),
   .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq));

// [tb/dtp_source_model.sv]
`timescale 1ns/1ps
module dtp_source_model (
   input wire logic clk,
   input wire logic clk_go,
   input wire logic irq_go,
   input wire logic [3:0] pulses,
   output logic tin_line,
   output logic ref_line
);
   initial begin
      tin_line = 1'b0;
      ref_line = 1'b0;
   end
   // High and low phases counted in system clocks, which exceed the input clock minimums
   always begin
      @(posedge clk);
      if (clk_go) begin
         repeat (pulses) begin
            tin_line <= 1'b1;
            repeat (5) @(posedge clk);
            tin_line <= 1'b0;
            repeat (3) @(posedge clk);
         end
      end
   end
   always begin
      @(posedge clk);
      if (irq_go) begin
         ref_line <= 1'b1;
         repeat (5) @(posedge clk);
         ref_line <= 1'b0;
      end
   end
endmodule

// [tb/dtp_timers_test.sv]
`timescale 1ns/1ps
module dtp_timers_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   dtp_pkg::dtp_reg_req_s reg_req = '0;
   logic [7:0] reg_rdata;
   logic [2:0] lines;
   logic tin_line;
   logic ref_line;
   logic stop_state = 1'b0;
   logic stop_release_pin = 1'b0;
   logic comparator_power_en;
   logic first_timer_irq;
   logic second_timer_irq;
   logic [5:0] irq_request;
   logic [3:0] port_input_irqs;
   logic clk_go = 1'b0;
   logic irq_go = 1'b0;
   logic first_cmp = 1'b0;
   logic second_cmp = 1'b0;
   logic [3:0] pulses = 4'h6;
   logic [7:0] held;
   int errors = 0;
   int n_compared = 0;
   int n;
   int hits;
   assign lines = {ref_line, 1'b0, tin_line};
   always #5 clk = ~clk;
   dtp_timers u_dtp_timers (.clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .input_port_lines(lines), .first_cmp_out(first_cmp), .second_cmp_out(second_cmp), .stop_state(stop_state),
      .stop_release_pin(stop_release_pin), .comparator_power_en(comparator_power_en),
      .irq_request(irq_request), .port_input_irqs(port_input_irqs), .first_timer_irq(first_timer_irq),
      .second_timer_irq(second_timer_irq));
   dtp_source_model u_dtp_source_model (.clk(clk), .clk_go(clk_go), .irq_go(irq_go), .pulses(pulses),
      .tin_line(tin_line), .ref_line(ref_line));
   task automatic finish_test;
      $display("Comparisons %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_n(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         errors++;
         $display("MISMATCH at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      reg_req <= '0;
      #1 v = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      check8(v, exp);
   endtask
   // Bounded so a dead timer ends the run instead of hanging it
   task automatic wait_irq(input logic second, output int cyc);
      cyc = 0;
      do begin
         @(posedge clk);
         #1 cyc++;
      end while (((second ? second_timer_irq : first_timer_irq) !== 1'b1) && cyc < 2000);
      if (cyc >= 2000) begin
         errors++;
         $display("MISMATCH at %0t: timer wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic count_irq(input logic second, input int cycles, output int h);
      h = 0;
      repeat (cycles) begin
         @(posedge clk);
         #1 if ((second ? second_timer_irq : first_timer_irq) === 1'b1) h++;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      rdc(dtp_pkg::ADDR_FIRST_PRESCALE, 8'h00);
      rdc(dtp_pkg::ADDR_SECOND_PRESCALE, 8'h00);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h00);
      rdc(8'h10, dtp_pkg::READ_ZERO);
      wr(dtp_pkg::ADDR_FIRST_COUNT, 8'h02);
      wr(dtp_pkg::ADDR_FIRST_PRESCALE, 8'h04);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h03);
      wait_irq(1'b0, n);
      check_n(int'(n >= 4 && n <= 9), 1);
      count_irq(1'b0, 40, hits);
      check_n(hits, 0);
      rdc(dtp_pkg::ADDR_FIRST_COUNT, 8'h00);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h10);
      wr(dtp_pkg::ADDR_IRQ_REQUEST, 8'h00);
      wr(dtp_pkg::ADDR_FIRST_COUNT, 8'h03);
      wr(dtp_pkg::ADDR_FIRST_PRESCALE, 8'h09);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h03);
      wait_irq(1'b0, n);
      wait_irq(1'b0, n);
      check_n(n, dtp_pkg::INTERNAL_DIV * 2 * 3);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      rd(dtp_pkg::ADDR_FIRST_COUNT, held);
      repeat (30) @(posedge clk);
      rdc(dtp_pkg::ADDR_FIRST_COUNT, held);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h02);
      wait_irq(1'b0, n);
      check_n(int'(n <= 24), 1);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      wr(dtp_pkg::ADDR_SECOND_COUNT, 8'h01);
      wr(dtp_pkg::ADDR_SECOND_PRESCALE, 8'h05);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h0c);
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      check_n(n, dtp_pkg::INTERNAL_DIV);
      wr(dtp_pkg::ADDR_SECOND_COUNT, 8'h00);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h0c);
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      check_n(n, dtp_pkg::INTERNAL_DIV * 256);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      wr(dtp_pkg::ADDR_SECOND_PRESCALE, 8'h07);
      wr(dtp_pkg::ADDR_SECOND_COUNT, 8'h02);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h0c);
      @(posedge clk);
      clk_go <= 1'b1;
      @(posedge clk);
      clk_go <= 1'b0;
      count_irq(1'b1, 70, hits);
      check_n(hits, 3);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      wr(dtp_pkg::ADDR_SECOND_PRESCALE, 8'h04);
      wr(dtp_pkg::ADDR_SECOND_COUNT, 8'h01);
      // Gate mode with the timer input low must hold the count
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h1c);
      count_irq(1'b1, 40, hits);
      check_n(hits, 0);
      // One-shot trigger mode waits for an input edge before counting
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h2c);
      count_irq(1'b1, 40, hits);
      check_n(hits, 0);
      @(posedge clk);
      pulses <= 4'h1;
      clk_go <= 1'b1;
      @(posedge clk);
      clk_go <= 1'b0;
      count_irq(1'b1, 40, hits);
      check_n(hits, 1);
      wr(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      wr(dtp_pkg::ADDR_IRQ_REQUEST, 8'h00);
      @(posedge clk);
      irq_go <= 1'b1;
      @(posedge clk);
      irq_go <= 1'b0;
      repeat (12) @(posedge clk);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h0a);
      wr(dtp_pkg::ADDR_INPUT_PORT_MODE, 8'h02);
      repeat (3) @(posedge clk);
      #1 check8({7'h00, comparator_power_en}, 8'h01);
      // An edge while the comparators settle only shows once they are valid
      second_cmp <= 1'b1;
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h0a);
      repeat (12) @(posedge clk);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h0b);
      wr(dtp_pkg::ADDR_IRQ_REQUEST, 8'h00);
      first_cmp <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h00);
      first_cmp <= 1'b0;
      second_cmp <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(dtp_pkg::ADDR_IRQ_REQUEST, 8'h05);
      @(posedge clk);
      stop_state <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check8({7'h00, comparator_power_en}, 8'h00);
      @(posedge clk);
      stop_state <= 1'b0;
      stop_release_pin <= 1'b1;
      @(posedge clk);
      stop_release_pin <= 1'b0;
      rdc(dtp_pkg::ADDR_INPUT_PORT_MODE, 8'h02);
      rdc(dtp_pkg::ADDR_TIMER_MODE, 8'h00);
      finish_test();
   end
endmodule
